// File: verilog/scpd_pkg.sv
package scpd_pkg;
   // Parameter block words, byte addresses
   localparam logic [7:0] OFS_PB_ID    = 8'h00;
   localparam logic [7:0] OFS_PB_ROUTE = 8'h04;
   localparam logic [7:0] OFS_PB_ADDR  = 8'h08;
   localparam logic [7:0] OFS_PB_COUNT = 8'h0C;
   localparam logic [7:0] OFS_PB_CDB0  = 8'h10;
   localparam logic [7:0] OFS_PB_CDB2  = 8'h18;
   // Control and status registers
   localparam logic [7:0] OFS_CTRL     = 8'h20;
   localparam logic [7:0] OFS_STAT     = 8'h24;
   localparam logic [7:0] OFS_IRQ_STS  = 8'h28;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
   localparam logic [7:0] OFS_SB_ID    = 8'h30;
   localparam logic [7:0] OFS_SB_INFO  = 8'h34;
   localparam int         PB_WORDS     = 7;
   // Fields of the route word
   localparam int FLG_LSB = 8;
   localparam int AM_LSB  = 16;
   localparam int TGT_LSB = 24;
   // Flag byte bit positions
   localparam int FLG_OVR  = 7;
   localparam int FLG_SUPP = 5;
   localparam int FLG_INHS = 3;
   localparam int FLG_DAT  = 2;
   localparam int FLG_DIR  = 1;
   localparam logic [7:0] AM_MASK = 8'h3F;
   // Status and error codes
   localparam logic [7:0] ST_CHECK      = 8'h02;
   localparam logic [7:0] ERR_NONE      = 8'h00;
   localparam logic [7:0] ERR_BAD_PHASE = 8'h24;
   // Control, status and interrupt bits
   localparam int CTRL_START = 0;
   localparam int STAT_BUSY  = 0;
   localparam int IRQ_DONE   = 0;
   localparam int IRQ_ERR    = 1;
   localparam int IRQ_W      = 2;
   localparam int INFO_SENSE = 16;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {
      SCPD_IDLE  = 3'b000,
      SCPD_ISSUE = 3'b001,
      SCPD_RUN   = 3'b011,
      SCPD_SENSE = 3'b010,
      SCPD_DONE  = 3'b110
   } scpd_state_e;

   // Command handed to the bus sequencer
   typedef struct packed {
      logic        req;
      logic        sense_req;
      logic        abort;
      logic [7:0]  target;
      logic [5:0]  addr_mod;
      logic [31:0] mem_addr;
      logic [31:0] count;
      logic        xfer_phase_present;
      logic        to_target;
      logic [95:0] cdb;
   } scpd_cmd_s;

   // Events reported by the bus sequencer
   typedef struct packed {
      logic       ack;
      logic       phase_valid;
      logic       phase_in;
      logic       status_valid;
      logic [7:0] status;
      logic       sense_done;
   } scpd_rsp_s;
endpackage : scpd_pkg

// File: verilog/scpd_decoder.sv
`timescale 1ns/1ps
// Summary of operation
// R1: Echo command identifier into status block.
// R2: Host keeps identifiers unique among outstanding.
// R3: Send CDB to target byte's ID.
// R4: Fixed layout: address, count, CDB words.
// R5: Low six address-modifier bits drive transfers.
// R6: Flag bits: override, suppress, sense, data, direction.
// R7: Direction counts only with override and data.
// R8: Direction zero from target, one to target.
// R9: Data bit zero no phase, one phase.
// R10: Auto request sense on check condition.
// R11: Inhibited sense: report check condition only.
// R12: Completion interrupt unless suppress bit set.
// R13: Override selects host bits, else defaults.
// R14: Opcode 04H defaults data to target.
// R15: Opcode 02H defaults to no data.
// R16: Override with zeros means no transfer.
// R17: Forward CDB, negotiate, report completion status.
// R18: Phase mismatch ends command with 24H.
// R19: Reserved flag and modifier bits ignored.
module scpd_decoder
(
   // Clock and reset
   input  wire logic              MCLK,
   input  wire logic              RESET,
   // Avalon-MM register slave
   input  wire logic [7:0]        AVS_ADDRESS,
   input  wire logic              AVS_READ,
   input  wire logic              AVS_WRITE,
   input  wire logic [31:0]       AVS_WRITEDATA,
   input  wire logic [3:0]        AVS_BYTEENABLE,
   output logic      [31:0]       AVS_READDATA,
   output logic                   AVS_WAITREQUEST,
   // Interrupt
   output logic                   IRQ,
   // Bus sequencer
   output scpd_pkg::scpd_cmd_s    SEQ_CMD,
   input  wire scpd_pkg::scpd_rsp_s SEQ_RSP
);
   import scpd_pkg::*;

   logic [31:0]       pb_ff [PB_WORDS];
   scpd_state_e       state_ff;
   scpd_cmd_s         cmd_ff;
   logic              supp_ff;
   logic              inhs_ff;
   logic [31:0]       sb_id_ff;
   logic [31:0]       sb_info_ff;
   logic [IRQ_W-1:0]  irq_sts_ff;
   logic [IRQ_W-1:0]  irq_mask_ff;
   logic              ack_ff;
   logic [31:0]       rdata_ff;
   logic              err_ff;
   logic              sensed_ff;
   logic [7:0]        scsi_st_ff;
   logic              wr_go;
   logic              rd_go;
   logic              start;
   logic              done_ev;
   logic              err_ev;
   logic [7:0]        flags;
   logic [7:0]        opcode;
   logic [1:0]        dflt;
   logic              nxt_dat;
   logic              nxt_dir;
   logic              mismatch;

   // Byte-lane merge for the parameter block words
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            r[8*i +: 8] = wd[8*i +: 8];
      end
      return r;
   endfunction : be_merge

   // Built-in per-opcode defaults, {data phase, to target}
   function automatic logic [1:0] op_default(input logic [7:0] op);
      logic [1:0] r;
      r = 2'b00;
      case (op)
         8'h04, 8'h07, 8'h0A, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1D,
         8'h2A, 8'h2E, 8'h30, 8'h31, 8'h32, 8'h33, 8'h39, 8'h3A,
         8'h3B, 8'h3F, 8'h40, 8'h41, 8'h4C, 8'h55, 8'hAA, 8'hAE,
         8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB6:
            r = 2'b11; // R14
         8'h03, 8'h05, 8'h08, 8'h0F, 8'h12, 8'h14, 8'h1A, 8'h1C,
         8'h25, 8'h28, 8'h2C, 8'h2D, 8'h37, 8'h3C, 8'h3E, 8'h4D,
         8'h5A, 8'hA4, 8'hA8, 8'hB5:
            r = 2'b10;
         default:
            r = 2'b00; // R15
      endcase
      return r;
   endfunction : op_default

   // One wait state on every access keeps read data registered
   assign wr_go = AVS_WRITE & ack_ff;
   assign rd_go = AVS_READ & ack_ff;
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_ff;
   assign AVS_READDATA = rdata_ff;

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         ack_ff <= 1'b0;
      else
         ack_ff <= (AVS_READ | AVS_WRITE) & ~ack_ff;
   end

   // Parameter block words; frozen while a command runs
   generate
      for (genvar w = 0; w < PB_WORDS; w++)
      begin : g_pb
         always_ff @(posedge MCLK or posedge RESET)
         begin
            if (RESET)
               pb_ff[w] <= RST_WORD;
            else if (wr_go && state_ff == SCPD_IDLE &&
                     AVS_ADDRESS == 8'(w * 4))
               pb_ff[w] <= be_merge(pb_ff[w], AVS_WRITEDATA, AVS_BYTEENABLE); // R4
         end
      end
   endgenerate

   assign start = wr_go && AVS_ADDRESS == OFS_CTRL &&
                  AVS_BYTEENABLE[0] && AVS_WRITEDATA[CTRL_START] &&
                  state_ff == SCPD_IDLE;

   // Effective data phase and direction
   assign flags  = pb_ff[OFS_PB_ROUTE[4:2]][FLG_LSB +: 8];
   assign opcode = pb_ff[OFS_PB_CDB0[4:2]][7:0];
   assign dflt   = op_default(opcode);
   always_comb
   begin
      if (flags[FLG_OVR]) // R13
      begin
         nxt_dat = flags[FLG_DAT]; // R9 R16
         nxt_dir = flags[FLG_DAT] & flags[FLG_DIR]; // R7 R8
      end
      else
      begin
         nxt_dat = dflt[1];
         nxt_dir = dflt[0];
      end
   end

   // Only the named flag bits are read, reserved ones never
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         supp_ff <= 1'b0;
         inhs_ff <= 1'b0;
      end
      else if (start)
      begin
         supp_ff <= flags[FLG_SUPP]; // R6 R19
         inhs_ff <= flags[FLG_INHS]; // R6
      end
   end

   // Latched command toward the sequencer
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         cmd_ff <= '0;
      else if (start)
      begin
         cmd_ff.target   <= pb_ff[OFS_PB_ROUTE[4:2]][TGT_LSB +: 8]; // R3
         cmd_ff.addr_mod <= 6'(pb_ff[OFS_PB_ROUTE[4:2]][AM_LSB +: 8] & AM_MASK); // R5 R19
         cmd_ff.mem_addr <= pb_ff[OFS_PB_ADDR[4:2]]; // R4
         cmd_ff.count    <= pb_ff[OFS_PB_COUNT[4:2]]; // R4
         cmd_ff.cdb      <= {pb_ff[OFS_PB_CDB2[4:2]], pb_ff[5], pb_ff[4]}; // R4
         cmd_ff.xfer_phase_present <= nxt_dat; // R13
         cmd_ff.to_target          <= nxt_dir; // R13
         cmd_ff.req       <= 1'b1; // R17
         cmd_ff.sense_req <= 1'b0;
         cmd_ff.abort     <= 1'b0;
      end
      else
      begin
         if (state_ff == SCPD_ISSUE && SEQ_RSP.ack)
            cmd_ff.req <= 1'b0;
         cmd_ff.abort <= state_ff == SCPD_RUN && mismatch; // R18
         if (state_ff == SCPD_RUN && SEQ_RSP.status_valid &&
             SEQ_RSP.status == ST_CHECK && !inhs_ff)
            cmd_ff.sense_req <= 1'b1; // R10
         else if (SEQ_RSP.sense_done)
            cmd_ff.sense_req <= 1'b0;
      end
   end
   assign SEQ_CMD = cmd_ff;

   // A data phase that the settings in effect do not expect
   // Judged only in RUN, so a stale phase after abort is harmless
   assign mismatch = SEQ_RSP.phase_valid &&
                     (!cmd_ff.xfer_phase_present ||
                      SEQ_RSP.phase_in == cmd_ff.to_target); // R18

   // Command sequence
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         state_ff <= SCPD_IDLE;
      else
      begin
         case (state_ff)
            SCPD_IDLE:
               if (start)
                  state_ff <= SCPD_ISSUE;
            SCPD_ISSUE:
               if (SEQ_RSP.ack)
                  state_ff <= SCPD_RUN; // R17
            SCPD_RUN:
               if (mismatch)
                  state_ff <= SCPD_DONE; // R18
               else if (SEQ_RSP.status_valid)
               begin
                  if (SEQ_RSP.status == ST_CHECK && !inhs_ff)
                     state_ff <= SCPD_SENSE; // R10
                  else
                     state_ff <= SCPD_DONE; // R11
               end
            SCPD_SENSE:
               if (SEQ_RSP.sense_done)
                  state_ff <= SCPD_DONE;
            SCPD_DONE:
               state_ff <= SCPD_IDLE;
            default:
               state_ff <= SCPD_IDLE;
         endcase
      end
   end

   // Outcome of the running command
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         err_ff     <= 1'b0;
         sensed_ff  <= 1'b0;
         scsi_st_ff <= 8'h00;
      end
      else if (start)
      begin
         err_ff     <= 1'b0;
         sensed_ff  <= 1'b0;
         scsi_st_ff <= 8'h00;
      end
      else
      begin
         if (state_ff == SCPD_RUN && mismatch)
            err_ff <= 1'b1; // R18
         if (state_ff == SCPD_RUN && SEQ_RSP.status_valid)
            scsi_st_ff <= SEQ_RSP.status; // R11
         if (state_ff == SCPD_SENSE && SEQ_RSP.sense_done)
            sensed_ff <= 1'b1; // R10
      end
   end

   // Status block, written once when the command ends
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         sb_id_ff   <= RST_WORD;
         sb_info_ff <= RST_WORD;
      end
      else if (state_ff == SCPD_DONE)
      begin
         sb_id_ff   <= pb_ff[OFS_PB_ID[4:2]]; // R1
         sb_info_ff <= {15'h0000, sensed_ff,
                        err_ff ? ERR_BAD_PHASE : ERR_NONE, scsi_st_ff}; // R17 R18
      end
   end

   // Phase faults always raise the error bit; only done obeys suppress
   assign done_ev = state_ff == SCPD_DONE && !supp_ff; // R12
   assign err_ev  = state_ff == SCPD_RUN && mismatch;

   // Sticky events; a new event wins over a same-cycle clear
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         irq_sts_ff <= '0;
      else
      begin
         logic [IRQ_W-1:0] clr;
         clr = '0;
         if (wr_go && AVS_ADDRESS == OFS_IRQ_STS && AVS_BYTEENABLE[0])
            clr = AVS_WRITEDATA[IRQ_W-1:0];
         irq_sts_ff <= (irq_sts_ff & ~clr) | {err_ev, done_ev}; // R12
      end
   end

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         irq_mask_ff <= '0;
      else if (wr_go && AVS_ADDRESS == OFS_IRQ_MASK && AVS_BYTEENABLE[0])
         irq_mask_ff <= AVS_WRITEDATA[IRQ_W-1:0];
   end

   assign IRQ = |(irq_sts_ff & irq_mask_ff);

   // Read mux; unmapped addresses read zero
   // Loaded in the wait cycle so read data come from a flop
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         rdata_ff <= RST_WORD;
      else if (AVS_READ & ~ack_ff)
      begin
         rdata_ff <= RST_WORD;
         if (AVS_ADDRESS < OFS_CTRL && AVS_ADDRESS[1:0] == 2'b00 &&
             AVS_ADDRESS[4:2] < 3'(PB_WORDS))
            rdata_ff <= pb_ff[AVS_ADDRESS[4:2]];
         else
         begin
            case (AVS_ADDRESS)
               OFS_STAT:     rdata_ff[STAT_BUSY] <= state_ff != SCPD_IDLE;
               OFS_IRQ_STS:  rdata_ff[IRQ_W-1:0] <= irq_sts_ff;
               OFS_IRQ_MASK: rdata_ff[IRQ_W-1:0] <= irq_mask_ff;
               OFS_SB_ID:    rdata_ff <= sb_id_ff;
               OFS_SB_INFO:  rdata_ff <= sb_info_ff;
               default:      rdata_ff <= RST_WORD;
            endcase
         end
      end
   end

   // Read strobe kept for symmetry; reads have no side effects
   logic unused_rd;
   assign unused_rd = rd_go;
endmodule : scpd_decoder

// File: tb/scpd_chk.sv
`timescale 1ns/1ps
module scpd_chk
(
   // Clock, reset and register bus
   input wire logic                MCLK,
   input wire logic                RESET,
   input wire logic [7:0]          AVS_ADDRESS,
   input wire logic                AVS_READ,
   input wire logic                AVS_WRITE,
   input wire logic [31:0]         AVS_WRITEDATA,
   input wire logic                AVS_WAITREQUEST,
   input wire logic                IRQ,
   // Sequencer side
   input wire scpd_pkg::scpd_cmd_s SEQ_CMD,
   input wire scpd_pkg::scpd_rsp_s SEQ_RSP
);
   import scpd_pkg::*;
   default clocking @(posedge MCLK); endclocking
   default disable iff (RESET);

   property p_wait;
      $rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer not after one wait");
   property p_start;
      $rose(SEQ_CMD.req) |-> $past(AVS_WRITE && !AVS_WAITREQUEST
         && AVS_ADDRESS == OFS_CTRL && AVS_WRITEDATA[CTRL_START]);
   endproperty
   a_start: assert property (p_start) else $error("request without start");
   property p_ack;
      SEQ_CMD.req && SEQ_RSP.ack |=> !SEQ_CMD.req;
   endproperty
   a_ack: assert property (p_ack) else $error("request held after ack");
   property p_dir;
      !SEQ_CMD.xfer_phase_present |-> !SEQ_CMD.to_target;
   endproperty
   a_dir: assert property (p_dir) else $error("direction without data phase");
   property p_bad;
      SEQ_RSP.phase_valid && (!SEQ_CMD.xfer_phase_present
         || SEQ_RSP.phase_in == SEQ_CMD.to_target) |=> SEQ_CMD.abort;
   endproperty
   a_bad: assert property (p_bad) else $error("wrong phase not aborted");
   property p_good;
      SEQ_RSP.phase_valid && SEQ_CMD.xfer_phase_present
         && SEQ_RSP.phase_in != SEQ_CMD.to_target |=> !SEQ_CMD.abort;
   endproperty
   a_good: assert property (p_good) else $error("expected phase aborted");
   property p_pulse;
      SEQ_CMD.abort |=> !SEQ_CMD.abort;
   endproperty
   a_pulse: assert property (p_pulse) else $error("abort longer than a cycle");
   property p_sense;
      $rose(SEQ_CMD.sense_req) |-> $past(SEQ_RSP.status_valid && SEQ_RSP.status == ST_CHECK);
   endproperty
   a_sense: assert property (p_sense) else $error("sense without check status");
   property p_sclr;
      SEQ_CMD.sense_req && SEQ_RSP.sense_done |=> !SEQ_CMD.sense_req;
   endproperty
   a_sclr: assert property (p_sclr) else $error("sense request stuck");
   c_abort: cover property (SEQ_CMD.abort);
   c_sense: cover property (SEQ_CMD.sense_req && SEQ_RSP.sense_done);
   c_irq: cover property ($rose(IRQ));
endmodule : scpd_chk

bind scpd_decoder scpd_chk i_chk (.MCLK, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
   .AVS_WRITEDATA, .AVS_WAITREQUEST, .IRQ, .SEQ_CMD, .SEQ_RSP);

// File: tb/scpd_target.sv
`timescale 1ns/1ps
module scpd_target
(
   // Clock and reset
   input  wire logic                MCLK,
   input  wire logic                RESET,
   // Decoder command and answer
   input  wire scpd_pkg::scpd_cmd_s cmd,
   output scpd_pkg::scpd_rsp_s      rsp,
   // Behaviour picked by the bench
   input  wire logic                ph_en,
   input  wire logic                ph_in,
   input  wire logic [7:0]          st,
   input  wire logic [3:0]          dly
);
   import scpd_pkg::*;
   logic [2:0] step_ff;
   logic [3:0] cnt_ff;
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         step_ff <= 3'h0;
         cnt_ff <= 4'h0;
         rsp <= '0;
      end
      else
      begin
         rsp <= '0;
         // Idle lines toggle so no stale value passes
         rsp.status <= ~rsp.status;
         rsp.phase_in <= ~rsp.phase_in;
         cnt_ff <= cnt_ff - 4'h1;
         case (step_ff)
            3'h0: if (cmd.req)
            begin
               step_ff <= 3'h1;
               cnt_ff <= dly;
            end
            3'h1: if (cnt_ff == 4'h0)
            begin
               rsp.ack <= 1'b1;
               step_ff <= 3'h2;
               cnt_ff <= 4'h2;
            end
            3'h2: if (cnt_ff == 4'h0)
            begin
               rsp.phase_valid <= ph_en;
               rsp.phase_in <= ph_in;
               step_ff <= 3'h3;
               cnt_ff <= 4'h2;
            end
            3'h3: if (cnt_ff == 4'h0)
            begin
               rsp.status_valid <= 1'b1;
               rsp.status <= st;
               step_ff <= 3'h4;
               cnt_ff <= 4'h3;
            end
            default: if (cmd.sense_req)
            begin
               rsp.sense_done <= 1'b1;
               step_ff <= 3'h0;
            end
            else if (cnt_ff == 4'h0)
               step_ff <= 3'h0;
         endcase
         if (cmd.abort)
            step_ff <= 3'h0;
      end
   end
endmodule : scpd_target

// File: tb/scpd_decoder_bench.sv
`timescale 1ns/1ps
module scpd_decoder_bench;
   import scpd_pkg::*;
   logic        mclk = 1'b0, reset = 1'b1, rd = 1'b0, wr = 1'b0;
   logic [7:0]  adr = 8'h00, st = 8'h00;
   logic [31:0] wd = 32'h0, rdat, junk;
   logic        wait_rq, irq, ph_en = 1'b0, ph_in = 1'b0;
   logic [3:0]  dly = 4'h1, be = 4'hF;
   scpd_cmd_s   cmd;
   scpd_rsp_s   rsp;
   int          failures = 0, n_checks = 0, n_cmd = 0;
   logic [7:0]  ops [6] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h0A, 8'h12};
   // Flags, opcode, phase enable and direction, status
   logic [31:0] corner [8] = '{32'h00040200, 32'h00020000, 32'h82040000, 32'h84020300,
      32'h00000002, 32'h08000002, 32'h20080300, 32'h00020200};
   initial forever #50 mclk = ~mclk;
   scpd_decoder i_scpd_decoder (.MCLK(mclk), .RESET(reset), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wait_rq), .IRQ(irq), .SEQ_CMD(cmd), .SEQ_RSP(rsp));
   scpd_target i_scpd_target (.MCLK(mclk), .RESET(reset), .cmd(cmd), .rsp(rsp),
      .ph_en(ph_en), .ph_in(ph_in), .st(st), .dly(dly));

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task finish_test;
      $display("checks %0d, failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      @(posedge mclk);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      i = 0;
      do
      begin
         @(posedge mclk);
         i++;
      end
      while (wait_rq !== 1'b0 && i < 20);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (wait_rq !== 1'b0)
      begin
         failures++;
         finish_test();
      end
   endtask : bus

   function logic [1:0] eff(input logic [7:0] f, input logic [7:0] op);
      if (f[FLG_OVR])
         return {f[FLG_DAT], f[FLG_DAT] & f[FLG_DIR]};
      case (op)
         8'h04, 8'h0A: return 2'b11;
         8'h08, 8'h12: return 2'b10;
         default: return 2'b00;
      endcase
   endfunction : eff

   task run_cmd(input logic [31:0] c);
      logic [31:0] id, rt, ma, cn, w0, w1, w2, q;
      logic [7:0]  f;
      logic [1:0]  dd, mk;
      logic        mm, sen;
      int          i;
      n_cmd++;
      id = {24'($urandom), 8'(n_cmd)};
      f = c[31:24] | (8'($urandom) & 8'h51);
      rt = {8'($urandom), 8'($urandom), f, 8'($urandom)};
      ma = $urandom;
      cn = $urandom;
      w0 = {24'($urandom), c[23:16]};
      w1 = $urandom;
      w2 = $urandom;
      mk = 2'($urandom);
      dd = eff(f, c[23:16]);
      mm = c[9] && (!dd[1] || c[8] == dd[0]);
      sen = c[7:0] == ST_CHECK && !f[FLG_INHS];
      ph_en <= c[9];
      ph_in <= c[8];
      st <= c[7:0];
      dly <= 4'($urandom_range(1, 6));
      bus(1, OFS_PB_ID, id, junk);
      bus(1, OFS_PB_ROUTE, rt, junk);
      bus(1, OFS_PB_ADDR, ma, junk);
      bus(1, OFS_PB_COUNT, cn, junk);
      bus(1, OFS_PB_CDB0, w0, junk);
      bus(1, OFS_PB_CDB0 + 8'h04, w1, junk);
      bus(1, OFS_PB_CDB2, w2, junk);
      bus(1, OFS_IRQ_MASK, {30'h0, mk}, junk);
      bus(1, OFS_CTRL, 32'h1, junk);
      for (i = 0; i < 20 && cmd.req !== 1'b1; i++)
         @(posedge mclk);
      check(cmd.req, 1'b1);
      check(cmd.target, rt[31:24]);
      check(cmd.addr_mod, rt[21:16]);
      check(cmd.mem_addr, ma);
      check(cmd.count, cn);
      check(cmd.cdb[31:0], w0);
      check(cmd.cdb[95:32], {w2, w1});
      check({cmd.xfer_phase_present, cmd.to_target}, dd);
      // Spoiler while busy must be ignored
      bus(1, OFS_PB_ID, ~id, junk);
      for (i = 0; i < 60; i++)
      begin
         bus(0, OFS_STAT, 32'h0, q);
         if (q[STAT_BUSY] === 1'b0)
            break;
      end
      if (i == 60)
      begin
         failures++;
         finish_test();
      end
      bus(0, OFS_SB_ID, 32'h0, q);
      check(q, id);
      bus(0, OFS_IRQ_STS, 32'h0, q);
      if (mm)
      begin
         check(q[IRQ_ERR], 1'b1);
         check(q[IRQ_DONE], !f[FLG_SUPP]);
         check(irq, (!f[FLG_SUPP] & mk[0]) | mk[1]);
         bus(0, OFS_SB_INFO, 32'h0, q);
         check(q[15:8], ERR_BAD_PHASE);
      end
      else
      begin
         check(q, {31'h0, !f[FLG_SUPP]});
         check(irq, !f[FLG_SUPP] & mk[0]);
         bus(0, OFS_SB_INFO, 32'h0, q);
         check(q, {15'h0, sen, ERR_NONE, c[7:0]});
      end
      bus(1, OFS_IRQ_STS, 32'h3, junk);
      bus(0, OFS_IRQ_STS, 32'h0, q);
      check(q, 32'h0);
      check(irq, 1'b0);
      $display("command %0d finished", n_cmd);
   endtask : run_cmd

   initial
   begin
      logic [31:0] q;
      q = $urandom(32);
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      bus(0, 8'h40, 32'h0, q);
      check(q, 32'h0);
      bus(1, OFS_PB_COUNT, 32'hFFFF_FFFF, junk);
      be <= 4'h5;
      bus(1, OFS_PB_COUNT, 32'h0, junk);
      be <= 4'hF;
      bus(0, OFS_PB_COUNT, 32'h0, q);
      check(q, 32'hFF00_FF00);
      $display("byte lane test finished");
      foreach (corner[k])
         run_cmd(corner[k]);
      repeat (16)
         run_cmd({8'($urandom) & 8'hAE, ops[$urandom_range(0, 5)], 6'h0, 2'($urandom),
            ($urandom_range(0, 1) ? ST_CHECK : ERR_NONE)});
      finish_test();
   end

   initial
   begin
      #2000000;
      failures++;
      finish_test();
   end
endmodule : scpd_decoder_bench
